// >>> hw/flash_read_end.sv
// Function
// - Quad read opcodes; address width follows mode
// - Dual read opcodes; address width follows mode
// - Quad data one nibble per falling edge
// - Host keeps clock at most 104 MHz
// - Quad read waits configured dummies, ignoring lines
// - Quad reads need the quad enable bit
// - Address increments per byte, wraps to zero
// - Dual address two bits per rising edge
// - Host keeps dual read clock under limit
// - Fast latency option has no mode cycles
// - Enhanced option adds four mode cycles to dual reads
// - Mode nibble A keeps continuous dual read
// - Only upper mode nibble decides continuation
// - Other nibble leaves continuous mode at deselect
// - Short invalid frame also leaves continuous mode
// - Host releases lines before first data
// - Dual data two bits per falling edge
// - Host keeps select low through mode, dummies
// - Dummy count comes from latency code
// - Wide address select widens legacy opcodes
// - Instruction byte one bit per rising edge
// - Dummies counted falling edge to falling edge
// - Deselect ends a read at any time
`timescale 1ns/1ps
`default_nettype none
module flash_read_end
	import spi_read_pkg::*;
#(
	parameter int          ARRAY_ADDR_W = 24,
	parameter logic [15:0] DUMMY_TABLE  = DUMMY_TABLE_DEFAULT
) (
	// Clock and reset
	input  wire logic                    CORE_CLK,
	input  wire logic                    SYS_RST,
	// Serial link
	spi_link_if.device                   LINK,
	// Configuration
	input  wire logic [7:0]              CONFIGURATION_REGISTER_ONE,
	input  wire logic                    WIDE_ADDRESS_SELECT,
	input  wire logic                    ENHANCED_LATENCY_OPTION,
	// Array read port
	output logic      [ARRAY_ADDR_W-1:0] MEM_ADDR,
	input  wire logic [7:0]              MEM_DATA,
	// Status
	output logic                         CONT_MODE
);
	if (ARRAY_ADDR_W < 8 || ARRAY_ADDR_W > 32) begin : g_bad_width
		$error("ARRAY_ADDR_W must lie in 8 to 32");
	end

	typedef struct packed {
		logic        sck_s1;
		logic        sck_s2;
		logic        sck_d;
		logic        cs_s1;
		logic        cs_s2;
		logic        cs_d;
		logic [3:0]  io_s1;
		logic [3:0]  io_s2;
		phase_t      phase;
		logic        quad;
		logic        wide;
		logic        cont;
		logic        cont_pend;
		logic [7:0]  shift;
		logic [5:0]  bits;
		logic [31:0] addr;
		logic [4:0]  dummy;
		logic [7:0]  obyte;
		logic [1:0]  slice;
		logic [4:0]  fclk;
		logic [3:0]  io_out;
		logic [3:0]  io_oe;
	} dev_state_t;

	dev_state_t r_reg;
	dev_state_t r_next;

	// Total latency for a code, less the mode beats that already count toward it
	function automatic logic [4:0] latency_of(input logic [1:0] code, input logic minus_mode);
		logic [4:0] total;
		total = {1'b0, DUMMY_TABLE[{code, 2'b00} +: 4]};
		if (minus_mode) begin
			latency_of = (total > 5'(MODE_BEATS)) ? total - 5'(MODE_BEATS) : 5'h00;
		end else begin
			latency_of = total;
		end
	endfunction

	// Lines for one data beat, MSB first
	function automatic logic [3:0] slice_of(input logic [7:0] b, input logic [1:0] idx,
		input logic q);
		logic [7:0] s;
		s = q ? (b << {idx, 2'b00}) : (b << {idx, 1'b0});
		slice_of = q ? s[7:4] : {2'b00, s[7:6]};
	endfunction

	// Next byte address inside the array, wrapping at the top
	function automatic logic [31:0] next_addr(input logic [31:0] a);
		logic [31:0] n;
		n = '0;
		n[ARRAY_ADDR_W-1:0] = a[ARRAY_ADDR_W-1:0] + 1'b1;
		next_addr = n;
	endfunction

	always_comb begin
		logic       rise;
		logic       fall;
		logic [7:0] op;
		logic [7:0] mode;
		logic [1:0] code;
		logic       wide;
		rise = r_reg.sck_s2 & ~r_reg.sck_d;
		fall = ~r_reg.sck_s2 & r_reg.sck_d;
		op = {r_reg.shift[6:0], r_reg.io_s2[0]};
		mode = {r_reg.shift[5:0], r_reg.io_s2[1:0]};
		code = CONFIGURATION_REGISTER_ONE[LATENCY_CODE_LSB +: 2];
		wide = 1'b0;
		r_next = r_reg;
		r_next.sck_s1 = LINK.sck;
		r_next.sck_s2 = r_reg.sck_s1;
		r_next.sck_d = r_reg.sck_s2;
		r_next.cs_s1 = LINK.cs_n;
		r_next.cs_s2 = r_reg.cs_s1;
		r_next.cs_d = r_reg.cs_s2;
		r_next.io_s1 = LINK.io;
		r_next.io_s2 = r_reg.io_s1;
		if (r_reg.cs_s2) begin
			r_next.phase = PH_IDLE;
			r_next.io_oe = '0;
			if (!r_reg.cs_d) begin
				// Decision taken at deselect; a short frame cannot be a valid address
				r_next.cont = r_reg.cont_pend && (r_reg.fclk > SHORT_FRAME_CLKS);
			end
		end else if (r_reg.cs_d) begin
			r_next.fclk = '0;
			r_next.cont_pend = 1'b0;
			r_next.addr = '0;
			if (r_reg.cont) begin
				// Continuous mode: first bits are already the address
				r_next.phase = PH_ADDR;
				r_next.quad = 1'b0;
				r_next.bits = (r_reg.wide ? WIDE_ADDR_BITS : NARROW_ADDR_BITS) >> 1;
			end else begin
				r_next.phase = PH_CMD;
				r_next.bits = CMD_BEATS;
			end
		end else begin
			if (rise) begin
				r_next.fclk = (r_reg.fclk == 5'h1F) ? r_reg.fclk : r_reg.fclk + 5'h01;
				r_next.bits = r_reg.bits - 6'h01;
				unique case (r_reg.phase)
					PH_CMD: begin
						r_next.shift = op;
						if (r_reg.bits == 6'h01) begin
							r_next.phase = PH_IGNORE;
							if (op == OP_QUAD_OUTPUT_READ || op == OP_QUAD_OUTPUT_READ_WIDE_ADDR) begin
								wide = (op == OP_QUAD_OUTPUT_READ_WIDE_ADDR) || WIDE_ADDRESS_SELECT;
								if (CONFIGURATION_REGISTER_ONE[QUAD_ENABLE_POS]) begin
									r_next.phase = PH_ADDR;
								end
								r_next.quad = 1'b1;
								r_next.wide = wide;
								r_next.bits = wide ? WIDE_ADDR_BITS : NARROW_ADDR_BITS;
							end else if (op == OP_DUAL_IO_READ || op == OP_DUAL_IO_READ_WIDE_ADDR) begin
								wide = (op == OP_DUAL_IO_READ_WIDE_ADDR) || WIDE_ADDRESS_SELECT;
								r_next.phase = PH_ADDR;
								r_next.quad = 1'b0;
								r_next.wide = wide;
								r_next.bits = (wide ? WIDE_ADDR_BITS : NARROW_ADDR_BITS) >> 1;
							end
						end
					end
					PH_ADDR: begin
						if (r_reg.quad) begin
							r_next.addr = {r_reg.addr[30:0], r_reg.io_s2[0]};
						end else begin
							r_next.addr = {r_reg.addr[29:0], r_reg.io_s2[1:0]};
						end
						if (r_reg.bits == 6'h01) begin
							if (!r_reg.quad && ENHANCED_LATENCY_OPTION) begin
								r_next.phase = PH_MODE;
								r_next.bits = MODE_BEATS;
							end else begin
								r_next.phase = PH_DUMMY;
								r_next.dummy = latency_of(code, 1'b0);
							end
						end
					end
					PH_MODE: begin
						r_next.shift = mode;
						if (r_reg.bits == 6'h01) begin
							// Low nibble may float, so it is never looked at
							r_next.cont_pend = (mode[7:4] == MODE_CONTINUE);
							r_next.phase = PH_DUMMY;
							r_next.dummy = latency_of(code, 1'b1);
						end
					end
					default: begin
					end
				endcase
			end
			if (fall) begin
				// Line values during dummies are never sampled
				if ((r_reg.phase == PH_DUMMY && r_reg.dummy == '0)
					|| (r_reg.phase == PH_DATA && r_reg.slice == (r_reg.quad ? 2'h1 : 2'h3))) begin
					r_next.phase = PH_DATA;
					r_next.obyte = MEM_DATA;
					r_next.slice = '0;
					r_next.io_out = slice_of(MEM_DATA, 2'h0, r_reg.quad);
					r_next.io_oe = r_reg.quad ? 4'hF : 4'h3;
					r_next.addr = next_addr(r_reg.addr);
				end else if (r_reg.phase == PH_DATA) begin
					r_next.slice = r_reg.slice + 2'h1;
					r_next.io_out = slice_of(r_reg.obyte, r_reg.slice + 2'h1, r_reg.quad);
				end else if (r_reg.phase == PH_DUMMY) begin
					r_next.dummy = r_reg.dummy - 5'h01;
				end
			end
		end
	end

	always_ff @(posedge CORE_CLK) begin
		if (SYS_RST) begin
			r_reg <= '0;
			// Select sync starts at its idle level so no false deselect follows reset
			r_reg.cs_s1 <= 1'b1;
			r_reg.cs_s2 <= 1'b1;
			r_reg.cs_d <= 1'b1;
		end else begin
			r_reg <= r_next;
		end
	end

	assign LINK.dev_io_out = r_reg.io_out;
	assign LINK.dev_io_oe = r_reg.io_oe;
	assign MEM_ADDR = r_reg.addr[ARRAY_ADDR_W-1:0];
	assign CONT_MODE = r_reg.cont;
endmodule // flash_read_end
`default_nettype wire

// >>> hw/spi_read_pkg.sv
package spi_read_pkg;
	// Read opcodes, always shifted in one bit per rising edge, MSB first
	localparam logic [7:0] OP_QUAD_OUTPUT_READ           = 8'h6B;
	localparam logic [7:0] OP_QUAD_OUTPUT_READ_WIDE_ADDR = 8'h6C;
	localparam logic [7:0] OP_DUAL_IO_READ               = 8'hBB;
	localparam logic [7:0] OP_DUAL_IO_READ_WIDE_ADDR     = 8'hBC;
	// Upper mode nibble that keeps continuous dual read alive
	localparam logic [3:0] MODE_CONTINUE = 4'hA;
	// Configuration register one fields
	localparam int QUAD_ENABLE_POS  = 1;
	localparam int LATENCY_CODE_LSB = 6;
	// Phase lengths: command and mode in serial clocks, address in bits
	localparam logic [5:0] CMD_BEATS       = 6'h08;
	localparam logic [5:0] NARROW_ADDR_BITS = 6'h18;
	localparam logic [5:0] WIDE_ADDR_BITS   = 6'h20;
	localparam logic [5:0] MODE_BEATS       = 6'h04;
	// A frame of this many clocks or fewer breaks continuous mode
	localparam logic [4:0] SHORT_FRAME_CLKS = 5'h08;
	// Latency lookup, four bits per latency code, code 0 lowest
	localparam logic [15:0] DUMMY_TABLE_DEFAULT = 16'h8642;
	// Serial clock limit against the core clock
	localparam int CORE_FREQ_KHZ = 50000;
	localparam int SCK_MAX_KHZ   = 104000;
	localparam int SCK_HALF_MIN  = (CORE_FREQ_KHZ + 2 * SCK_MAX_KHZ - 1) / (2 * SCK_MAX_KHZ);
	// Two sync flops plus one edge flop must settle inside a half period
	localparam int SYNC_HALF_MIN = 4;
	localparam int SCK_HALF_DEFAULT = 4;

	typedef enum logic [2:0] {
		PH_IDLE,
		PH_CMD,
		PH_ADDR,
		PH_MODE,
		PH_DUMMY,
		PH_DATA,
		PH_IGNORE
	} phase_t;
endpackage

// >>> hw/spi_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface spi_link_if;
	logic       sck;
	logic       cs_n;
	logic [3:0] host_io_out;
	logic [3:0] host_io_oe;
	logic [3:0] dev_io_out;
	logic [3:0] dev_io_oe;
	logic [3:0] io;

	// Undriven lines float high through a pull-up
	assign io = (dev_io_oe & dev_io_out) | (~dev_io_oe & host_io_oe & host_io_out)
		| (~dev_io_oe & ~host_io_oe);

	modport device (input sck, input cs_n, input io, output dev_io_out, output dev_io_oe);
	modport host (output sck, output cs_n, output host_io_out, output host_io_oe, input io);
endinterface
`default_nettype wire

// >>> hw/flash_host_end.sv
`timescale 1ns/1ps
`default_nettype none
module flash_host_end
	import spi_read_pkg::*;
#(
	parameter int SCK_HALF_CYCLES = SCK_HALF_DEFAULT
) (
	// Clock and reset
	input  wire logic        CORE_CLK,
	input  wire logic        SYS_RST,
	// Serial link
	spi_link_if.host         LINK,
	// Request
	input  wire logic        START,
	input  wire logic        DUAL_SEL,
	input  wire logic        WIDE_OPCODE,
	input  wire logic        WIDE_ADDR,
	input  wire logic        ENHANCED,
	input  wire logic        SKIP_CMD,
	input  wire logic [7:0]  MODE_BYTE,
	input  wire logic [4:0]  DUMMY_BEATS,
	input  wire logic [31:0] ADDR,
	input  wire logic [15:0] BYTE_COUNT,
	// Answer
	output logic             BUSY,
	output logic [7:0]       RD_DATA,
	output logic             RD_VALID
);
	if (SCK_HALF_CYCLES < SCK_HALF_MIN || SCK_HALF_CYCLES < SYNC_HALF_MIN
		|| SCK_HALF_CYCLES > 127) begin : g_bad_half
		$error("SCK_HALF_CYCLES out of range");
	end

	localparam logic [7:0] HALF_LAST = 8'(SCK_HALF_CYCLES - 1);
	localparam logic [7:0] GAP_LAST  = 8'(2 * SCK_HALF_CYCLES - 1);

	typedef struct packed {
		phase_t      phase;
		logic        sck;
		logic        cs_n;
		logic [7:0]  div;
		logic        dual;
		logic        wide;
		logic        enh;
		logic [4:0]  dmy;
		logic [31:0] adr;
		logic [7:0]  mode;
		logic [15:0] bytes;
		logic [31:0] sh;
		logic [5:0]  beats;
		logic [7:0]  rx;
		logic [1:0]  rxs;
		logic [3:0]  io_s1;
		logic [3:0]  io_s2;
		logic [3:0]  io_out;
		logic [3:0]  io_oe;
		logic [7:0]  rd_data;
		logic        rd_valid;
		logic        busy;
	} host_state_t;

	host_state_t r_reg;
	host_state_t r_next;

	always_comb begin
		logic beat_start;
		logic [5:0] abits;
		beat_start = 1'b0;
		abits = (r_reg.wide) ? WIDE_ADDR_BITS : NARROW_ADDR_BITS;
		r_next = r_reg;
		r_next.io_s1 = LINK.io;
		r_next.io_s2 = r_reg.io_s1;
		r_next.rd_valid = 1'b0;
		unique case (r_reg.phase)
			PH_IDLE: begin
				r_next.sck = 1'b0;
				r_next.io_oe = '0;
				if (START) begin
					r_next.busy = 1'b1;
					r_next.cs_n = 1'b0;
					r_next.div = '0;
					r_next.dual = DUAL_SEL;
					r_next.wide = WIDE_OPCODE | WIDE_ADDR;
					r_next.enh = ENHANCED;
					r_next.dmy = DUMMY_BEATS;
					r_next.mode = MODE_BYTE;
					r_next.bytes = BYTE_COUNT;
					r_next.rxs = '0;
					beat_start = 1'b1;
					if (SKIP_CMD && DUAL_SEL) begin
						r_next.phase = PH_ADDR;
						r_next.sh = (WIDE_OPCODE | WIDE_ADDR) ? ADDR : {ADDR[23:0], 8'h00};
						r_next.beats = ((WIDE_OPCODE | WIDE_ADDR) ? WIDE_ADDR_BITS
							: NARROW_ADDR_BITS) >> 1;
						r_next.adr = ADDR;
					end else begin
						r_next.phase = PH_CMD;
						r_next.beats = CMD_BEATS;
						r_next.adr = ADDR;
						if (DUAL_SEL) begin
							r_next.sh = {(WIDE_OPCODE ? OP_DUAL_IO_READ_WIDE_ADDR
								: OP_DUAL_IO_READ), 24'h00_0000};
						end else begin
							r_next.sh = {(WIDE_OPCODE ? OP_QUAD_OUTPUT_READ_WIDE_ADDR
								: OP_QUAD_OUTPUT_READ), 24'h00_0000};
						end
					end
				end
			end
			PH_IGNORE: begin
				// Chip select stays high for two half periods between frames
				r_next.div = r_reg.div + 8'h01;
				if (r_reg.div == GAP_LAST) begin
					r_next.phase = PH_IDLE;
					r_next.busy = 1'b0;
				end
			end
			default: begin
				// Clock divider keeps the link within its rate limit
				r_next.div = r_reg.div + 8'h01;
				if (r_reg.div == HALF_LAST) begin
					r_next.div = '0;
					r_next.sck = ~r_reg.sck;
					if (r_reg.sck) begin
						beat_start = 1'b1;
						r_next.beats = r_reg.beats - 6'h01;
						if (r_reg.phase == PH_DATA) begin
							r_next.rx = r_reg.dual ? {r_reg.rx[5:0], r_reg.io_s2[1:0]}
								: {r_reg.rx[3:0], r_reg.io_s2};
							r_next.rxs = r_reg.rxs + 2'h1;
							if (r_reg.rxs == (r_reg.dual ? 2'h3 : 2'h1)) begin
								r_next.rxs = '0;
								r_next.rd_data = r_next.rx;
								r_next.rd_valid = 1'b1;
								r_next.bytes = r_reg.bytes - 16'h0001;
								if (r_reg.bytes == 16'h0001) begin
									r_next.phase = PH_IGNORE;
									r_next.cs_n = 1'b1;
									r_next.sck = 1'b0;
									r_next.io_oe = '0;
									beat_start = 1'b0;
								end
							end
						end else if (r_reg.beats == 6'h01) begin
							unique case (r_reg.phase)
								PH_CMD: begin
									r_next.phase = PH_ADDR;
									r_next.sh = r_reg.wide ? r_reg.adr : {r_reg.adr[23:0], 8'h00};
									r_next.beats = r_reg.dual ? (abits >> 1) : abits;
								end
								PH_ADDR: begin
									if (r_reg.dual && r_reg.enh) begin
										r_next.phase = PH_MODE;
										r_next.sh = {r_reg.mode, 24'h00_0000};
										r_next.beats = MODE_BEATS;
									end else begin
										r_next.phase = (r_reg.dmy == '0) ? PH_DATA : PH_DUMMY;
										r_next.beats = {1'b0, r_reg.dmy};
									end
								end
								default: begin
									r_next.phase = (r_reg.dmy == '0 || r_reg.phase == PH_DUMMY)
										? PH_DATA : PH_DUMMY;
									r_next.beats = {1'b0, r_reg.dmy};
								end
							endcase
						end
					end
				end
			end
		endcase
		// Every beat starts on a falling edge, or at select for the first: put the next bits out
		if (beat_start) begin
			r_next.io_oe = '0;
			if (r_next.phase == PH_CMD || (r_next.phase == PH_ADDR && !r_next.dual)) begin
				r_next.io_out = {3'b000, r_next.sh[31]};
				r_next.io_oe = 4'h1;
				r_next.sh = {r_next.sh[30:0], 1'b0};
			end else if (r_next.phase == PH_ADDR || r_next.phase == PH_MODE) begin
				r_next.io_out = {2'b00, r_next.sh[31:30]};
				// Low mode nibble is left floating to free the bus early
				r_next.io_oe = (r_next.phase == PH_MODE && r_next.beats <= 6'h02)
					? 4'h0 : 4'h3;
				r_next.sh = {r_next.sh[29:0], 2'b00};
			end
		end
	end

	always_ff @(posedge CORE_CLK) begin
		if (SYS_RST) begin
			r_reg <= '0;
			r_reg.cs_n <= 1'b1;
		end else begin
			r_reg <= r_next;
		end
	end

	// Chip select only rises once all data beats are done
	assign LINK.cs_n = r_reg.cs_n;
	assign LINK.sck = r_reg.sck;
	assign LINK.host_io_out = r_reg.io_out;
	assign LINK.host_io_oe = r_reg.io_oe;
	assign BUSY = r_reg.busy;
	assign RD_DATA = r_reg.rd_data;
	assign RD_VALID = r_reg.rd_valid;
endmodule // flash_host_end
`default_nettype wire

// >>> test/serial_flash_multi_io_read_properties.sv
`timescale 1ns/1ps
`default_nettype none
module serial_flash_multi_io_read_properties (
	// Clock and reset
	input wire logic       CORE_CLK,
	input wire logic       SYS_RST,
	// Link
	input wire logic       sck,
	input wire logic       cs_n,
	input wire logic [3:0] host_io_out,
	input wire logic [3:0] host_io_oe,
	input wire logic [3:0] dev_io_out,
	input wire logic [3:0] dev_io_oe
);
	logic       sck_q;
	logic [3:0] age_reg;
	logic [3:0] age;

	// Core cycles since the last falling serial edge, saturating
	assign age = (sck_q && !sck) ? 4'h0 : ((age_reg == 4'hF) ? age_reg : age_reg + 4'h1);

	always_ff @(posedge CORE_CLK) begin
		if (SYS_RST) begin
			sck_q   <= 1'b0;
			age_reg <= 4'hF;
		end else begin
			sck_q   <= sck;
			age_reg <= age;
		end
	end

	default clocking cb @(posedge CORE_CLK); endclocking
	default disable iff (SYS_RST);

	property p_no_contention;
		(dev_io_oe & host_io_oe) == 4'h0;
	endproperty
	a_no_contention: assert property (p_no_contention) else $error("both ends drive io");

	property p_quiet_deselect;
		cs_n [*6] |-> dev_io_oe == 4'h0;
	endproperty
	a_quiet_deselect: assert property (p_quiet_deselect) else $error("device drives deselected");

	// Sync latency is 3 to 4 cycles, so a change past 5 followed a rising edge
	property p_dev_on_fall;
		$changed(dev_io_out) && dev_io_oe != 4'h0 && !cs_n |-> age <= 4'h5;
	endproperty
	a_dev_on_fall: assert property (p_dev_on_fall) else $error("data not moved on fall");

	property p_sck_half;
		$rose(sck) |-> sck [*4] ##1 !sck;
	endproperty
	a_sck_half: assert property (p_sck_half) else $error("serial clock high time wrong");

	property p_host_on_fall;
		$changed(host_io_out) && host_io_oe != 4'h0 && !cs_n && $past(cs_n) == 1'b0 |-> age <= 4'h1;
	endproperty
	a_host_on_fall: assert property (p_host_on_fall) else $error("host bit not moved on fall");

	property p_release_first;
		$rose(dev_io_oe != 4'h0) |-> $past(host_io_oe) == 4'h0;
	endproperty
	a_release_first: assert property (p_release_first) else $error("host still driving");

	property p_oe_width;
		dev_io_oe inside {4'h0, 4'h3, 4'hF};
	endproperty
	a_oe_width: assert property (p_oe_width) else $error("device lane set wrong");

	property p_cs_rise_low;
		$rose(cs_n) |-> !sck;
	endproperty
	a_cs_rise_low: assert property (p_cs_rise_low) else $error("deselect with clock high");

	c_quad_data: cover property ($rose(dev_io_oe == 4'hF));
	c_dual_data: cover property ($rose(dev_io_oe == 4'h3));
	c_frame_end: cover property ($rose(cs_n));
endmodule // serial_flash_multi_io_read_properties
`default_nettype wire

// >>> test/serial_flash_multi_io_read_test.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin miscompares++; \
	$display("[FAIL] %0t got %0h exp %0h", $time, a, e); end end
module serial_flash_multi_io_read_test;
	import spi_read_pkg::*;
	logic        core_clk = 1'b0;
	logic        sys_rst = 1'b1;
	logic        start = 1'b0, dual_sel = 1'b0, wide_opcode = 1'b0, wide_addr = 1'b0;
	logic        enhanced = 1'b0, skip_cmd = 1'b0, wide_sel = 1'b0, enh_opt = 1'b0;
	logic [7:0]  mode_byte = 8'h00, cr1 = 8'h00, rd_data, mem_data, opc;
	logic [4:0]  dummy_beats = 5'h00;
	logic [31:0] addr = 32'h0000_0000;
	logic [15:0] byte_count = 16'h0001, mem_addr;
	logic        busy, rd_valid, cont_mode, sck_q;
	int          miscompares = 0, checked = 0, rises = 0, oe_cycles = 0;

	spi_link_if link();
	always #10 core_clk = ~core_clk;
	// Array model: byte mixes both address bytes so a missed wrap shows
	assign mem_data = mem_addr[7:0] ^ mem_addr[15:8];

	flash_host_end i_flash_host_end (.CORE_CLK(core_clk), .SYS_RST(sys_rst), .LINK(link),
		.START(start), .DUAL_SEL(dual_sel), .WIDE_OPCODE(wide_opcode), .WIDE_ADDR(wide_addr),
		.ENHANCED(enhanced), .SKIP_CMD(skip_cmd), .MODE_BYTE(mode_byte),
		.DUMMY_BEATS(dummy_beats), .ADDR(addr), .BYTE_COUNT(byte_count), .BUSY(busy),
		.RD_DATA(rd_data), .RD_VALID(rd_valid));
	flash_read_end #(.ARRAY_ADDR_W(16)) i_flash_read_end (.CORE_CLK(core_clk),
		.SYS_RST(sys_rst), .LINK(link), .CONFIGURATION_REGISTER_ONE(cr1),
		.WIDE_ADDRESS_SELECT(wide_sel), .ENHANCED_LATENCY_OPTION(enh_opt),
		.MEM_ADDR(mem_addr), .MEM_DATA(mem_data), .CONT_MODE(cont_mode));
	serial_flash_multi_io_read_properties i_serial_flash_multi_io_read_properties (
		.CORE_CLK(core_clk), .SYS_RST(sys_rst), .sck(link.sck), .cs_n(link.cs_n),
		.host_io_out(link.host_io_out), .host_io_oe(link.host_io_oe),
		.dev_io_out(link.dev_io_out), .dev_io_oe(link.dev_io_oe));

	// Second device on a bench-driven link, for frames the host end never makes
	spi_link_if  link_b();
	logic        cont_b;
	logic [15:0] mem_addr_b;
	flash_read_end #(.ARRAY_ADDR_W(16)) i_flash_read_end_b (.CORE_CLK(core_clk),
		.SYS_RST(sys_rst), .LINK(link_b), .CONFIGURATION_REGISTER_ONE(cr1),
		.WIDE_ADDRESS_SELECT(wide_sel), .ENHANCED_LATENCY_OPTION(enh_opt),
		.MEM_ADDR(mem_addr_b), .MEM_DATA(mem_addr_b[7:0]), .CONT_MODE(cont_b));

	// Wire watch: opcode bits on io0 and rising edges per frame
	always @(posedge core_clk) begin
		sck_q <= link.sck;
		if (link.dev_io_oe != 4'h0) oe_cycles++;
		if (link.sck && !sck_q && !link.cs_n) begin
			if (rises < 8) opc <= {opc[6:0], link.io[0]};
			rises++;
		end
	end

	task automatic end_sim();
		$display("checked %0d miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	task automatic xfer(input logic d, wo, wa, en, sk, qe, drv, input logic [1:0] lc,
		input logic [7:0] mb, op, input logic [23:0] a, input int n);
		int tot;
		int dum;
		int beats;
		int got;
		logic [15:0] ea;
		tot = 2 + 2 * lc;
		dum = (d && en) ? ((tot > 4) ? tot - 4 : 0) : tot;
		beats = (sk ? 0 : 8) + ((wo || wa) ? 32 : 24) / (d ? 2 : 1) + ((d && en) ? 4 : 0)
			+ dum + n * (d ? 4 : 2);
		got = 0;
		rises = 0;
		oe_cycles = 0;
		@(posedge core_clk);
		cr1 <= {lc, 4'h0, qe, 1'b0};
		wide_sel <= wa;
		enh_opt <= en;
		dual_sel <= d;
		wide_opcode <= wo;
		wide_addr <= wa;
		enhanced <= en;
		skip_cmd <= sk;
		mode_byte <= mb;
		dummy_beats <= 5'(dum);
		addr <= {8'h00, a};
		byte_count <= 16'(n);
		start <= 1'b1;
		@(posedge core_clk);
		start <= 1'b0;
		for (int i = 0; i < 4000 && got < n; i++) begin
			@(posedge core_clk);
			#1;
			if (rd_valid === 1'b1) begin
				ea = a[15:0] + 16'(got);
				`CHK(rd_data, drv ? (ea[7:0] ^ ea[15:8]) : 8'hFF)
				got++;
			end
		end
		for (int i = 0; i < 400 && busy !== 1'b0; i++) begin
			@(posedge core_clk);
			#1;
		end
		`CHK(busy, 1'b0)
		`CHK(got, n)
		`CHK(rises, beats)
		if (!sk) `CHK(opc, op)
		`CHK(oe_cycles == 0, !drv)
	endtask

	task automatic t_quad_wrap();
		xfer(0, 0, 0, 0, 0, 1, 1, 2'd1, 8'h00, OP_QUAD_OUTPUT_READ, 24'hFF_FFFE, 4);
		$display("test quad_wrap done");
	endtask

	task automatic t_quad_wide();
		xfer(0, 1, 0, 0, 0, 1, 1, 2'd3, 8'h00, OP_QUAD_OUTPUT_READ_WIDE_ADDR, 24'h12_3456, 2);
		xfer(0, 0, 1, 0, 0, 1, 1, 2'd2, 8'h00, OP_QUAD_OUTPUT_READ, 24'h00_ABCD, 2);
		$display("test quad_wide done");
	endtask

	task automatic t_quad_off();
		xfer(0, 0, 0, 0, 0, 0, 0, 2'd0, 8'h00, OP_QUAD_OUTPUT_READ, 24'h00_0010, 2);
		`CHK(cont_mode, 1'b0)
		$display("test quad_off done");
	endtask

	task automatic t_dual_fast();
		xfer(1, 0, 0, 0, 0, 1, 1, 2'd1, 8'hA5, OP_DUAL_IO_READ, 24'h00_C3D2, 3);
		`CHK(cont_mode, 1'b0)
		xfer(1, 0, 1, 0, 0, 1, 1, 2'd0, 8'h00, OP_DUAL_IO_READ, 24'h00_7E81, 2);
		$display("test dual_fast done");
	endtask

	task automatic t_dual_cont();
		xfer(1, 0, 0, 1, 0, 1, 1, 2'd0, 8'hA5, OP_DUAL_IO_READ, 24'h00_0123, 2);
		`CHK(cont_mode, 1'b1)
		xfer(1, 0, 0, 1, 1, 1, 1, 2'd2, 8'hA0, 8'h00, 24'h00_4455, 2);
		`CHK(cont_mode, 1'b1)
		xfer(1, 0, 0, 1, 1, 1, 1, 2'd2, 8'h5A, 8'h00, 24'h00_AA00, 1);
		`CHK(cont_mode, 1'b0)
		xfer(1, 1, 0, 1, 0, 1, 1, 2'd3, 8'h00, OP_DUAL_IO_READ_WIDE_ADDR, 24'h00_FFFF, 2);
		$display("test dual_cont done");
	endtask

	// One serial period on the bench link; bits change with the falling edge
	task automatic beat_b(input logic [1:0] v);
		link_b.host_io_out <= {2'b00, v};
		repeat (4) @(posedge core_clk);
		link_b.sck <= 1'b1;
		repeat (4) @(posedge core_clk);
		link_b.sck <= 1'b0;
	endtask

	task automatic t_short_frame();
		logic [7:0] op_b;
		op_b = OP_DUAL_IO_READ;
		@(posedge core_clk);
		cr1 <= 8'h02;
		enh_opt <= 1'b1;
		wide_sel <= 1'b0;
		link_b.cs_n <= 1'b0;
		link_b.host_io_oe <= 4'h3;
		for (int i = 7; i >= 0; i--) begin
			beat_b({1'b0, op_b[i]});
		end
		repeat (12) beat_b(2'b01);
		beat_b(2'b10);
		beat_b(2'b10);
		link_b.host_io_oe <= 4'h0;
		repeat (2) beat_b(2'b00);
		repeat (8) @(posedge core_clk);
		link_b.cs_n <= 1'b1;
		repeat (12) @(posedge core_clk);
		`CHK(cont_b, 1'b1)
		// Eight clocks only: too short to be an address, so continuous mode ends
		link_b.cs_n <= 1'b0;
		repeat (8) beat_b(2'b11);
		repeat (4) @(posedge core_clk);
		link_b.cs_n <= 1'b1;
		repeat (12) @(posedge core_clk);
		`CHK(cont_b, 1'b0)
		$display("test short_frame done");
	endtask

	initial begin
		#400_000;
		miscompares++;
		end_sim();
	end

	initial begin
		link_b.sck <= 1'b0;
		link_b.cs_n <= 1'b1;
		link_b.host_io_out <= 4'h0;
		link_b.host_io_oe <= 4'h0;
		repeat (4) @(posedge core_clk);
		sys_rst <= 1'b0;
		t_quad_wrap();
		t_quad_wide();
		t_quad_off();
		t_dual_fast();
		t_dual_cont();
		t_short_frame();
		end_sim();
	end
endmodule // serial_flash_multi_io_read_test
`default_nettype wire
